//--- rtl/two_wire_slave_defs.svh
// Register indices, field positions and reset values of the two-wire slave
// Functional notes
// - Stop sets address/stop flag when enabled
// - Promiscuous bit answers every received address
// - Smart mode: data access continues operation
// - Slave works only once enabled
// - Ack action bit picks ACK or NACK
// - Ack action bit is plain stored bit
// - Command field is strobe, reads zero
// - Command zero does nothing; one reserved
// - Complete: ack if master writes, then wait for start
// - Response after address: ack, then continue
// - Response after data: ack or send byte
// - One write sets ack and command together
// - Data flag set, cleared by access
// - Address/stop flag set, cleared by access
// - Address and stop share one request
// - Pending data or address flag holds SCL low
// - Latest master acknowledge bit is kept
// - Collision stops SDA low drive, still completes
// - Collision clears on write or start
// - Misplaced start or stop flags bus error
// - Bus error only with master enabled
// - Direction bit from last address
// - Cause bit: address one, stop zero
// - Data request needs enable, flag, global
`ifndef TWO_WIRE_SLAVE_DEFS_SVH
`define TWO_WIRE_SLAVE_DEFS_SVH
`define IDX_MCTRL_A 4'h3
`define IDX_SCTRL_A 4'h9
`define IDX_SCTRL_B 4'hA
`define IDX_STATUS 4'hB
`define IDX_OWN_ADDR 4'hC
`define IDX_DATA 4'hD
`define RESET_BYTE 8'h00
`define CMD_CMD_NO_ACTION 2'h0
`define CMD_RESERVED 2'h1
`define CMD_COMPLETE 2'h2
`define CMD_RESPONSE 2'h3
`define BIT_ACK_ACTION 2
`define BIT_DATA_FLAG 7
`define BIT_AS_FLAG 6
`define BIT_COLLISION_FLAG 3
`define BIT_BUS_ERROR_FLAG 2
`define LAST_BIT 4'h7
`define BYTE_BITS 4'h8
`endif

//--- rtl/two_wire_slave_pkg.sv
// Types shared by the two-wire slave
package two_wire_slave_pkg;
   typedef struct packed {
      logic data_irq_en;
      logic addr_stop_irq_en;
      logic stop_irq_en;
      logic [1:0] unused;
      logic promiscuous_addr_en;
      logic smart_mode_en;
      logic enable;
   } ctrl_a_t;
   typedef enum logic [3:0] {
      ST_IDLE, ST_ADDR, ST_PRE, ST_HOLD, ST_ACK_OUT, ST_RX, ST_TX,
      ST_ACK_IN, ST_WAIT
   } slave_state_t;
   typedef enum logic [1:0] {NA_RX, NA_DIF, NA_WAIT} after_ack_t;
endpackage

//--- rtl/two_wire_slave.sv
// Two-wire bus slave with Avalon-MM control and status registers
//
// Implementation choice: the Avalon-MM slave port.
`timescale 1ns/1ps
`default_nettype none
`include "two_wire_slave_defs.svh"
module two_wire_slave
   import two_wire_slave_pkg::*;
(
   input wire logic clk,
   input wire logic rst_n,
   input wire logic [5:0] address,
   input wire logic read,
   input wire logic write,
   input wire logic [3:0] byteenable,
   input wire logic [31:0] writedata,
   output logic [31:0] readdata,
   output logic waitrequest,
   input wire logic global_irq_en,
   output logic irq_data,
   output logic irq_addr_stop,
   input wire logic scl_in,
   output logic scl_out,
   output logic scl_drive_n,
   input wire logic sda_in,
   output logic sda_out,
   output logic sda_drive_n
);
   // -----------------------------------------------------------------
   // Bus slave
   // -----------------------------------------------------------------
   logic resp_reg;
   logic [7:0] rdata_reg;
   logic [7:0] rdata_next;
   logic [3:0] idx;
   logic fire;
   logic wr_fire;
   logic rd_data;
   logic wr_data;
   logic data_acc;
   logic cmd_wr;
   logic [1:0] cmd;
   logic ctl_wr;
   ctrl_a_t ctrl_a_reg;
   logic master_en_reg;
   logic ack_action_reg;
   logic [7:0] own_addr_reg;
   logic [7:0] data_reg;
   logic data_flag;
   logic addr_stop_flag;
   logic received_ack_bit;
   logic collision_flag;
   logic bus_error_flag;
   logic dir_reg;
   logic irq_cause;
   logic [7:0] status;
   slave_state_t state_reg;
   logic in_hold;

   assign idx = address[5:2];
   // One wait state keeps read data registered at the accepting edge
   assign waitrequest = (read | write) & ~resp_reg;
   assign fire = (read | write) & resp_reg;
   assign wr_fire = fire & write & byteenable[0];
   assign rd_data = fire & read & (idx == `IDX_DATA);
   assign wr_data = wr_fire & (idx == `IDX_DATA);
   assign data_acc = rd_data | wr_data;
   assign cmd_wr = wr_fire & (idx == `IDX_SCTRL_B);
   assign cmd = writedata[1:0];
   assign ctl_wr = wr_fire & (idx == `IDX_STATUS);
   assign readdata = {24'h000000, rdata_reg};
   assign status = {data_flag, addr_stop_flag, in_hold, received_ack_bit,
                    collision_flag, bus_error_flag, dir_reg, irq_cause};

   always_comb begin
      case (idx)
         `IDX_MCTRL_A: rdata_next = {7'h00, master_en_reg};
         `IDX_SCTRL_A: rdata_next = ctrl_a_reg;
         `IDX_SCTRL_B: rdata_next = {5'h00, ack_action_reg, 2'h0};
         `IDX_STATUS: rdata_next = status;
         `IDX_OWN_ADDR: rdata_next = own_addr_reg;
         `IDX_DATA: rdata_next = data_reg;
         default: rdata_next = `RESET_BYTE;
      endcase
   end

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         resp_reg <= 1'b0;
         rdata_reg <= `RESET_BYTE;
      end else begin
         resp_reg <= (read | write) & ~resp_reg;
         if (read & ~resp_reg) begin
            rdata_reg <= rdata_next;
         end
      end
   end

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         ctrl_a_reg <= `RESET_BYTE;
         master_en_reg <= 1'b0;
         ack_action_reg <= 1'b0;
         own_addr_reg <= `RESET_BYTE;
      end else if (wr_fire) begin
         case (idx)
            `IDX_MCTRL_A: master_en_reg <= writedata[0];
            `IDX_SCTRL_A: ctrl_a_reg <= {writedata[7:5], 2'b00,
                                         writedata[2:0]};
            `IDX_SCTRL_B: ack_action_reg <= writedata[`BIT_ACK_ACTION];
            `IDX_OWN_ADDR: own_addr_reg <= writedata[7:0];
            default: ;
         endcase
      end
   end

   // -----------------------------------------------------------------
   // Pin synchronisers and bus conditions
   // -----------------------------------------------------------------
   logic [2:0] scl_sync;
   logic [2:0] sda_sync;
   logic scl_s;
   logic sda_s;
   logic scl_rise;
   logic scl_fall;
   logic start_c;
   logic stop_c;

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         scl_sync <= 3'h7;
         sda_sync <= 3'h7;
      end else begin
         scl_sync <= {scl_sync[1:0], scl_in};
         sda_sync <= {sda_sync[1:0], sda_in};
      end
   end

   // Edges need the clock at four times SCL or faster
   assign scl_s = scl_sync[1];
   assign sda_s = sda_sync[1];
   assign scl_rise = scl_s & ~scl_sync[2];
   assign scl_fall = ~scl_s & scl_sync[2];
   assign start_c = scl_s & scl_sync[2] & sda_sync[2] & ~sda_s;
   assign stop_c = scl_s & scl_sync[2] & ~sda_sync[2] & sda_s;

   // -----------------------------------------------------------------
   // Slave sequencer
   // -----------------------------------------------------------------
   logic [3:0] cnt_reg;
   logic pre_addr_reg;
   logic ctx_addr_reg;
   logic ack_val_reg;
   logic ack_seen_reg;
   after_ack_t after_reg;
   logic en;
   logic ack_now;
   logic go;
   logic complete;
   logic [7:0] in_byte;
   logic match;
   logic mid_byte;
   logic ev_start;
   logic ev_stop;
   logic ev_addr;
   logic ev_data;
   logic ev_collision_flag;
   logic ev_collision_flag_nack;
   logic ev_bus_error_flag;

   assign en = ctrl_a_reg.enable;
   assign in_hold = state_reg == ST_HOLD;
   assign ack_now = cmd_wr ? writedata[`BIT_ACK_ACTION] : ack_action_reg;
   assign go = in_hold & ((cmd_wr & cmd == `CMD_RESPONSE) |
                          (ctrl_a_reg.smart_mode_en & data_acc));
   assign complete = in_hold & cmd_wr & cmd == `CMD_COMPLETE;
   assign in_byte = {data_reg[6:0], sda_s};
   assign match = ctrl_a_reg.promiscuous_addr_en |
                  (in_byte[7:1] == own_addr_reg[7:1]) |
                  (own_addr_reg[0] & in_byte == `RESET_BYTE);
   assign mid_byte = (state_reg == ST_RX | state_reg == ST_TX |
                      state_reg == ST_ADDR) &
                     cnt_reg != 4'h0 & cnt_reg != `BYTE_BITS;
   assign ev_start = en & start_c;
   assign ev_stop = en & stop_c;
   assign ev_addr = en & state_reg == ST_PRE & pre_addr_reg & scl_fall;
   assign ev_data = en & scl_fall & ~start_c & ~stop_c &
                    ((state_reg == ST_PRE & ~pre_addr_reg) |
                     (state_reg == ST_ACK_IN & ack_seen_reg) |
                     (state_reg == ST_ACK_OUT & ack_seen_reg &
                      after_reg == NA_DIF & ~ack_val_reg));
   assign ev_collision_flag_nack = en & scl_rise & ~sda_s &
                         state_reg == ST_ACK_OUT & ack_val_reg;
   assign ev_collision_flag = ev_collision_flag_nack | (en & scl_rise & ~sda_s &
                    state_reg == ST_TX & cnt_reg < `BYTE_BITS &
                    data_reg[7]);
   assign ev_bus_error_flag = master_en_reg &
                      ((ev_start & mid_byte) |
                       (ev_stop & (mid_byte | state_reg == ST_ADDR)));

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         state_reg <= ST_IDLE;
         cnt_reg <= 4'h0;
         data_reg <= `RESET_BYTE;
         pre_addr_reg <= 1'b0;
         ctx_addr_reg <= 1'b0;
         ack_val_reg <= 1'b0;
         ack_seen_reg <= 1'b0;
         after_reg <= NA_WAIT;
      end else if (!en) begin
         state_reg <= ST_IDLE;
         if (wr_data) begin
            data_reg <= writedata[7:0];
         end
      end else if (start_c) begin
         state_reg <= ST_ADDR;
         cnt_reg <= 4'h0;
      end else if (stop_c) begin
         state_reg <= ST_IDLE;
      end else begin
         case (state_reg)
            ST_ADDR: if (scl_rise) begin
               data_reg <= in_byte;
               cnt_reg <= cnt_reg + 4'h1;
               if (cnt_reg == `LAST_BIT) begin
                  pre_addr_reg <= 1'b1;
                  state_reg <= match ? ST_PRE : ST_WAIT;
               end
            end
            ST_RX: if (scl_rise) begin
               data_reg <= in_byte;
               cnt_reg <= cnt_reg + 4'h1;
               if (cnt_reg == `LAST_BIT) begin
                  pre_addr_reg <= 1'b0;
                  state_reg <= ST_PRE;
               end
            end
            ST_PRE: if (scl_fall) begin
               ctx_addr_reg <= pre_addr_reg;
               state_reg <= ST_HOLD;
            end
            ST_HOLD: begin
               if (wr_data) begin
                  data_reg <= writedata[7:0];
               end
               ack_seen_reg <= 1'b0;
               cnt_reg <= 4'h0;
               if (go) begin
                  ack_val_reg <= ack_now;
                  state_reg <= ST_ACK_OUT;
                  if (ctx_addr_reg) begin
                     after_reg <= dir_reg ? NA_DIF : NA_RX;
                  end else if (!dir_reg) begin
                     after_reg <= NA_RX;
                  end else begin
                     state_reg <= ST_TX;
                  end
               end else if (complete) begin
                  ack_val_reg <= ack_now;
                  after_reg <= NA_WAIT;
                  state_reg <= dir_reg ? ST_WAIT : ST_ACK_OUT;
               end
            end
            ST_ACK_OUT: begin
               if (scl_rise) begin
                  ack_seen_reg <= 1'b1;
               end
               if (scl_fall & ack_seen_reg) begin
                  cnt_reg <= 4'h0;
                  ack_seen_reg <= 1'b0;
                  if (ack_val_reg | after_reg == NA_WAIT) begin
                     state_reg <= ST_WAIT;
                  end else if (after_reg == NA_RX) begin
                     state_reg <= ST_RX;
                  end else begin
                     ctx_addr_reg <= 1'b0;
                     state_reg <= ST_HOLD;
                  end
               end
            end
            ST_TX: begin
               if (scl_rise) begin
                  cnt_reg <= cnt_reg + 4'h1;
               end
               if (scl_fall & cnt_reg != 4'h0) begin
                  data_reg <= {data_reg[6:0], 1'b1};
                  if (cnt_reg == `BYTE_BITS) begin
                     state_reg <= ST_ACK_IN;
                  end
               end
            end
            ST_ACK_IN: begin
               if (scl_rise) begin
                  ack_seen_reg <= 1'b1;
               end
               if (scl_fall & ack_seen_reg) begin
                  ctx_addr_reg <= 1'b0;
                  state_reg <= ST_HOLD;
               end
            end
            default: ;
         endcase
      end
   end

   // -----------------------------------------------------------------
   // Status flags; a set in the same cycle as a clear wins
   // -----------------------------------------------------------------
   logic flag_clr;
   assign flag_clr = data_acc | (cmd_wr & cmd[1]);

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         data_flag <= 1'b0;
      end else if (ev_data) begin
         data_flag <= 1'b1;
      end else if (flag_clr | (ctl_wr & writedata[`BIT_DATA_FLAG])) begin
         data_flag <= 1'b0;
      end
   end

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         addr_stop_flag <= 1'b0;
         irq_cause <= 1'b0;
      end else if (ev_addr | ev_collision_flag_nack) begin
         addr_stop_flag <= 1'b1;
         irq_cause <= 1'b1;
      end else if (ev_stop & ctrl_a_reg.stop_irq_en) begin
         addr_stop_flag <= 1'b1;
         irq_cause <= 1'b0;
      end else if (flag_clr | (ctl_wr & writedata[`BIT_AS_FLAG])) begin
         addr_stop_flag <= 1'b0;
      end
   end

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         collision_flag <= 1'b0;
      end else if (ev_collision_flag) begin
         collision_flag <= 1'b1;
      end else if (ev_start | (ctl_wr & writedata[`BIT_COLLISION_FLAG])) begin
         collision_flag <= 1'b0;
      end
   end

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         bus_error_flag <= 1'b0;
      end else if (ev_bus_error_flag) begin
         bus_error_flag <= 1'b1;
      end else if (ctl_wr & writedata[`BIT_BUS_ERROR_FLAG]) begin
         bus_error_flag <= 1'b0;
      end
   end

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         dir_reg <= 1'b0;
         received_ack_bit <= 1'b0;
      end else begin
         if (en & state_reg == ST_ADDR & scl_rise & ~start_c & ~stop_c &
             cnt_reg == `LAST_BIT & match) begin
            dir_reg <= sda_s;
         end
         if (en & state_reg == ST_ACK_IN & scl_rise) begin
            received_ack_bit <= sda_s;
         end
      end
   end

   // -----------------------------------------------------------------
   // Pins and requests
   // -----------------------------------------------------------------
   assign scl_out = 1'b0;
   assign sda_out = 1'b0;
   assign scl_drive_n = ~(en & in_hold);
   // A collision stops SDA low drive (not the SCL hold) until the next start or a status write clears it
   assign sda_drive_n = ~(en & ~collision_flag &
                          ((state_reg == ST_ACK_OUT & ~ack_val_reg) |
                           (state_reg == ST_TX & ~data_reg[7])));
   assign irq_data = ctrl_a_reg.data_irq_en & data_flag & global_irq_en;
   assign irq_addr_stop = ctrl_a_reg.addr_stop_irq_en & addr_stop_flag &
                          global_irq_en;

   // -----------------------------------------------------------------
   // Assertions
   // -----------------------------------------------------------------
   default clocking @(posedge clk); endclocking
   default disable iff (!rst_n);

   sequence s_addr_last;
      en && state_reg == ST_ADDR && scl_rise && !start_c && !stop_c &&
         cnt_reg == `LAST_BIT;
   endsequence
   sequence s_hold_go;
      in_hold && go;
   endsequence

   property p_stop_flag;
      ev_stop && ctrl_a_reg.stop_irq_en && !ev_addr && !ev_collision_flag_nack
         |=> addr_stop_flag && !irq_cause;
   endproperty
   a_stop_flag: assert property (p_stop_flag)
      else $error("stop did not raise address/stop flag");
   property p_promisc;
      s_addr_last ##0 ctrl_a_reg.promiscuous_addr_en |=> state_reg == ST_PRE;
   endproperty
   a_promisc: assert property (p_promisc)
      else $error("promiscuous address not accepted");
   property p_smart;
      s_hold_go |=> !in_hold && scl_drive_n;
   endproperty
   a_smart: assert property (p_smart)
      else $error("hold not released on continue");
   property p_disabled;
      !en |-> scl_drive_n && sda_drive_n;
   endproperty
   a_disabled: assert property (p_disabled)
      else $error("disabled slave drives a line");
   property p_cmd_zero;
      fire && read && idx == `IDX_SCTRL_B |-> readdata[1:0] == 2'h0;
   endproperty
   a_cmd_zero: assert property (p_cmd_zero)
      else $error("command field read back nonzero");
   property p_collision_flag_start;
      ev_start && !ev_collision_flag |=> !collision_flag;
   endproperty
   a_collision_flag_start: assert property (p_collision_flag_start)
      else $error("collision flag kept over start");
   property p_cmd_no_action;
      in_hold && cmd_wr && cmd == `CMD_CMD_NO_ACTION && !start_c && !stop_c
         |=> in_hold [*2];
   endproperty
   a_cmd_no_action: assert property (p_cmd_no_action)
      else $error("no-action command moved the slave");
   property p_data_hold;
      ev_data |=> data_flag && !scl_drive_n;
   endproperty
   a_data_hold: assert property (p_data_hold)
      else $error("data event without flag and clock hold");
   property p_received_ack_bit;
      en && state_reg == ST_ACK_IN && scl_rise
         |=> received_ack_bit == $past(sda_s);
   endproperty
   a_received_ack_bit: assert property (p_received_ack_bit)
      else $error("received acknowledge not captured");
endmodule
`default_nettype wire

//--- sim/wire_master_model.sv
// Behavioural two-wire bus master driving the far side of the slave
`timescale 1ns/1ps
`default_nettype none
module wire_master_model (
   input wire logic clk,
   input wire logic scl_w,
   input wire logic sda_w,
   output logic scl_m,
   output logic sda_m
);
   // ----------------------------------------
   // Line idle and bit timing
   // ----------------------------------------
   // Clock stands high outside frames
   initial begin
      scl_m = 1'b1;
      sda_m = 1'b1;
   end
   task automatic half();
      repeat (3) @(posedge clk);
   endtask
   // Waits out clock stretching; bound keeps a stuck slave visible
   task automatic rise();
      int n;
      scl_m <= 1'b1;
      @(posedge clk);
      n = 0;
      while (scl_w !== 1'b1 && n < 5000) begin
         @(posedge clk);
         n++;
      end
   endtask
   task automatic bit_io(input logic b, output logic r);
      @(posedge clk);
      sda_m <= b;
      half();
      rise();
      half();
      r = sda_w;
      scl_m <= 1'b0;
   endtask
   // ----------------------------------------
   // Frame level operations
   // ----------------------------------------
   task automatic start();
      @(posedge clk);
      sda_m <= 1'b1;
      half();
      rise();
      sda_m <= 1'b0;
      half();
      scl_m <= 1'b0;
      half();
   endtask
   task automatic stop();
      @(posedge clk);
      sda_m <= 1'b0;
      half();
      rise();
      half();
      sda_m <= 1'b1;
      half();
   endtask
   task automatic tx(input logic [7:0] d, output logic ack);
      logic r;
      for (int i = 7; i >= 0; i--) bit_io(d[i], r);
      bit_io(1'b1, ack);
   endtask
   task automatic rx(input logic a, output logic [7:0] d);
      logic r;
      for (int i = 7; i >= 0; i--) begin
         bit_io(1'b1, r);
         d[i] = r;
      end
      bit_io(a, r);
   endtask
endmodule
`default_nettype wire

//--- sim/tb.sv
// Register-level testbench of the two-wire slave
`timescale 1ns/1ps
`default_nettype none
`include "two_wire_slave_defs.svh"
module tb;
   import two_wire_slave_pkg::*;
   logic clk, rst_n, read, write, global_irq_en;
   logic [5:0] address;
   logic [3:0] byteenable;
   logic [31:0] writedata, readdata;
   logic waitrequest, irq_data, irq_addr_stop;
   logic scl_out, scl_drive_n, sda_out, sda_drive_n;
   logic scl_m, sda_m, scl_w, sda_w, ack;
   logic [7:0] q, d;
   int fails, total_checks;
   int cyc = 0;
   // Open-drain lines: anyone pulling low wins
   assign scl_w = scl_m & (scl_drive_n | scl_out);
   assign sda_w = sda_m & (sda_drive_n | sda_out);
   two_wire_slave dut (.clk(clk), .rst_n(rst_n), .address(address),
      .read(read), .write(write), .byteenable(byteenable),
      .writedata(writedata), .readdata(readdata),
      .waitrequest(waitrequest), .global_irq_en(global_irq_en),
      .irq_data(irq_data), .irq_addr_stop(irq_addr_stop),
      .scl_in(scl_w), .scl_out(scl_out), .scl_drive_n(scl_drive_n),
      .sda_in(sda_w), .sda_out(sda_out), .sda_drive_n(sda_drive_n));
   wire_master_model m (.clk(clk), .scl_w(scl_w), .sda_w(sda_w),
      .scl_m(scl_m), .sda_m(sda_m));
   // ----------------------------------------
   // Clock, timeout and helpers
   // ----------------------------------------
   initial begin
      clk = 1'b0;
      forever #20 clk = ~clk;
   end
   task automatic end_sim();
      if (fails == 0 && total_checks > 0) $display("TEST PASSED");
      else $display("TEST FAILED");
      $finish;
   endtask
   always @(posedge clk) begin
      cyc <= cyc + 1;
      if (cyc == 40000) begin
         fails++;
         end_sim();
      end
   end
   task automatic chk(input logic [7:0] got, input logic [7:0] exp);
      total_checks++;
      if (got !== exp) begin
         fails++;
         $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask
   // Avalon access: held until waitrequest is seen low at a rising edge
   task automatic bus(input logic [3:0] idx, input logic wr,
                      input logic [7:0] dw, output logic [7:0] qr);
      @(posedge clk);
      address <= {idx, 2'b00};
      writedata <= {24'h000000, dw};
      write <= wr;
      read <= ~wr;
      do @(posedge clk); while (waitrequest !== 1'b0);
      qr = readdata[7:0];
      write <= 1'b0;
      read <= 1'b0;
   endtask
   task automatic wr(input logic [3:0] idx, input logic [7:0] dw);
      logic [7:0] x;
      bus(idx, 1'b1, dw, x);
   endtask
   task automatic rd(input logic [3:0] idx);
      bus(idx, 1'b0, 8'h00, q);
   endtask
   // Polls status until the given bit is set, bounded
   task automatic wait_bit(input int b);
      for (int n = 0; n < 300; n++) begin
         rd(`IDX_STATUS);
         if (q[b] === 1'b1) break;
      end
      chk({7'h00, q[b]}, 8'h01);
   endtask
   // ----------------------------------------
   // Scenarios
   // ----------------------------------------
   initial begin
      rst_n = 1'b0;
      read = 1'b0;
      write = 1'b0;
      address = 6'h00;
      byteenable = 4'h1;
      writedata = 32'h00000000;
      global_irq_en = 1'b1;
      fails = 0;
      total_checks = 0;
      repeat (5) @(posedge clk);
      rst_n <= 1'b1;
      rd(`IDX_SCTRL_A); chk(q, 8'h00);
      rd(`IDX_SCTRL_B); chk(q, 8'h00);
      rd(`IDX_STATUS); chk(q, 8'h00);
      rd(4'h0); chk(q, 8'h00);
      wr(`IDX_SCTRL_B, 8'h04);
      rd(`IDX_SCTRL_B); chk(q, 8'h04);
      wr(`IDX_SCTRL_B, 8'h00);
      wr(`IDX_OWN_ADDR, 8'hA0);
      m.start();
      m.tx(8'hA0, ack); chk({7'h00, ack}, 8'h01);
      rd(`IDX_STATUS); chk(q, 8'h00);
      m.stop();
      rd(`IDX_STATUS); chk({7'h00, q[2]}, 8'h00);
      wr(`IDX_SCTRL_A, 8'hC3);
      rd(`IDX_SCTRL_A); chk(q, 8'hC3);
      m.start();
      m.tx(8'hB0, ack); chk({7'h00, ack}, 8'h01);
      m.stop();
      rd(`IDX_STATUS); chk(q, 8'h00);
      m.start();
      fork
         m.tx(8'hA0, ack);
         begin
            wait_bit(`BIT_AS_FLAG);
            chk(q, 8'h61);
            chk({7'h00, irq_addr_stop}, 8'h01);
            wr(`IDX_SCTRL_B, 8'h03);
         end
      join
      chk({7'h00, ack}, 8'h00);
      fork
         m.tx(8'h5A, ack);
         begin
            wait_bit(`BIT_DATA_FLAG);
            chk(q & 8'hE0, 8'hA0);
            chk({7'h00, irq_data}, 8'h01);
            global_irq_en <= 1'b0;
            @(posedge clk);
            chk({7'h00, irq_data}, 8'h00);
            global_irq_en <= 1'b1;
            rd(`IDX_DATA); chk(q, 8'h5A);
         end
      join
      chk({7'h00, ack}, 8'h00);
      rd(`IDX_STATUS); chk(q & 8'hE0, 8'h00);
      wr(`IDX_SCTRL_A, 8'hE3);
      fork
         m.tx(8'h33, ack);
         begin
            wait_bit(`BIT_DATA_FLAG);
            wr(`IDX_SCTRL_B, 8'h06);
         end
      join
      chk({7'h00, ack}, 8'h01);
      rd(`IDX_SCTRL_B); chk(q, 8'h04);
      m.stop();
      wait_bit(`BIT_AS_FLAG);
      chk(q & 8'hC1, 8'h40);
      wr(`IDX_STATUS, 8'h40);
      rd(`IDX_STATUS); chk(q & 8'hC0, 8'h00);
      wr(`IDX_SCTRL_B, 8'h00);
      m.start();
      fork
         m.tx(8'hA1, ack);
         begin
            wait_bit(`BIT_AS_FLAG);
            chk(q, 8'h63);
            wr(`IDX_SCTRL_B, 8'h03);
         end
      join
      fork
         m.rx(1'b0, d);
         begin
            wait_bit(`BIT_DATA_FLAG);
            wr(`IDX_DATA, 8'hC3);
         end
      join
      chk(d, 8'hC3);
      fork
         m.rx(1'b1, d);
         begin
            wait_bit(`BIT_DATA_FLAG);
            chk({7'h00, q[4]}, 8'h00);
            wr(`IDX_DATA, 8'h3C);
         end
      join
      chk(d, 8'h3C);
      wait_bit(`BIT_DATA_FLAG);
      chk({7'h00, q[4]}, 8'h01);
      wr(`IDX_SCTRL_B, 8'h02);
      m.stop();
      wait_bit(`BIT_AS_FLAG);
      wr(`IDX_STATUS, 8'hC0);
      m.start();
      m.stop();
      rd(`IDX_STATUS); chk({7'h00, q[2]}, 8'h00);
      // Start straight into stop is a misplaced condition
      wr(`IDX_MCTRL_A, 8'h01);
      m.start();
      m.stop();
      wait_bit(`BIT_BUS_ERROR_FLAG);
      wr(`IDX_STATUS, 8'h44);
      rd(`IDX_STATUS); chk({7'h00, q[2]}, 8'h00);
      // Fresh start after the error; promiscuous, collided read
      wr(`IDX_SCTRL_A, 8'hE7);
      m.start();
      fork
         m.tx(8'hB1, ack);
         begin
            wait_bit(`BIT_AS_FLAG);
            wr(`IDX_SCTRL_B, 8'h00);
            rd(`IDX_STATUS); chk(q, 8'h73);
            wr(`IDX_SCTRL_B, 8'h03);
         end
      join
      fork
         m.tx(8'h00, ack);
         begin
            wait_bit(`BIT_DATA_FLAG);
            wr(`IDX_DATA, 8'h80);
         end
      join
      wait_bit(`BIT_DATA_FLAG);
      chk({7'h00, q[3]}, 8'h01);
      wr(`IDX_SCTRL_B, 8'h02);
      m.start();
      rd(`IDX_STATUS); chk({7'h00, q[3]}, 8'h00);
      end_sim();
   end
endmodule
`default_nettype wire
